/* File: mpmi_top.sv */
// Overview of operation
// - Drive one nibble on txd per tx clock period while tx_en is high.
// - Serial coder mode sends on txd bit 0 only, others unused.
// - Capture an rx nibble each rx clock period while rx_dv is high.
// - rx_er marks the frame errored, but only while rx_dv is high.
// - Serial coder mode receives on rxd bit 0 only.
// - Carrier sense is asynchronous and is synchronised before use.
// - Collision is ignored in full-duplex mode.
// - Management clock phases at least 160 ns, period at least 400 ns.
// - Management clock may pause without limit between transfers.
// - Device drives management data in writes, in step with the clock.
// - tx_en rises with first nibble, falls just after the next tx clock rise after last.
`timescale 1ns/1ps
`default_nettype none
module mpmi_top (
    // System
    input wire logic ref_clk,
    input wire logic rst_n,
    // Mode
    input wire logic serial_coder_10m_mode,
    input wire logic full_duplex,
    // Transmit user side
    input wire logic tx_valid,
    input wire logic [mpmi_pkg::NIB_W-1:0] tx_nibble,
    output logic tx_taken,
    // Receive user side
    output logic rx_nib_valid,
    output logic [mpmi_pkg::NIB_W-1:0] rx_nib,
    output logic rx_frame_end,
    output logic rx_frame_err,
    // Medium status
    output logic carrier_sense,
    output logic collision,
    // Management user side
    input wire logic mgmt_start,
    input wire logic mgmt_write,
    input wire logic [4:0] mgmt_phy_addr,
    input wire logic [4:0] mgmt_reg_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic mgmt_busy,
    output logic mgmt_done,
    output logic [15:0] mgmt_rdata,
    // PHY pins
    input wire logic phy_tx_clk,
    output logic phy_tx_en,
    output logic [mpmi_pkg::NIB_W-1:0] phy_txd,
    input wire logic phy_rx_clk,
    input wire logic phy_rx_dv,
    input wire logic phy_rx_er,
    input wire logic [mpmi_pkg::NIB_W-1:0] phy_rxd,
    input wire logic phy_crs,
    input wire logic phy_col,
    output logic phy_mdc,
    input wire logic phy_mdio_i,
    output logic phy_mdio_o,
    output logic phy_mdio_oe
);
    import mpmi_pkg::*;

    // Two-stage synchronisers; stage one feeds stage two only.
    logic [10:0] sync1_r;
    logic [10:0] sync2_r;
    logic tx_clk_d_r;
    logic rx_clk_d_r;
    logic tx_clk_s, rx_clk_s, rx_dv_s, rx_er_s, crs_s, col_s, mdio_s;
    logic [3:0] rxd_s;
    logic tx_rise, rx_fall;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            tx_clk_d_r <= 1'b0;
            rx_clk_d_r <= 1'b0;
        end else begin
            sync1_r <= {phy_mdio_i, phy_col, phy_crs, phy_rxd, phy_rx_er,
                        phy_rx_dv, phy_rx_clk, phy_tx_clk};
            sync2_r <= sync1_r;
            tx_clk_d_r <= sync2_r[0];
            rx_clk_d_r <= sync2_r[1];
        end
    end

    assign tx_clk_s = sync2_r[0];
    assign rx_clk_s = sync2_r[1];
    assign rx_dv_s = sync2_r[2];
    assign rx_er_s = sync2_r[3];
    assign rxd_s = sync2_r[7:4];
    assign crs_s = sync2_r[8];
    assign col_s = sync2_r[9];
    assign mdio_s = sync2_r[10];
    assign tx_rise = tx_clk_s & ~tx_clk_d_r;
    // Sampling mid-period keeps us clear of the PHY's data transitions.
    assign rx_fall = ~rx_clk_s & rx_clk_d_r;

    // Transmit: a new nibble is launched just after each tx clock rise.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phy_tx_en <= 1'b0;
            phy_txd <= TXD_RST;
            tx_taken <= 1'b0;
        end else begin
            tx_taken <= 1'b0;
            if (tx_rise) begin
                phy_tx_en <= tx_valid;
                tx_taken <= tx_valid;
                if (tx_valid) begin
                    phy_txd <= mpmi_lane_sel(serial_coder_10m_mode,
                                             tx_nibble);
                end else begin
                    phy_txd <= TXD_RST;
                end
            end
        end
    end

    // Receive.
    logic rx_in_frame_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_in_frame_r <= 1'b0;
            rx_nib_valid <= 1'b0;
            rx_nib <= TXD_RST;
            rx_frame_end <= 1'b0;
            rx_frame_err <= 1'b0;
        end else begin
            rx_nib_valid <= 1'b0;
            rx_frame_end <= 1'b0;
            if (rx_fall) begin
                rx_in_frame_r <= rx_dv_s;
                if (rx_dv_s) begin
                    rx_nib_valid <= 1'b1;
                    rx_nib <= mpmi_lane_sel(serial_coder_10m_mode,
                                            rxd_s);
                    if (!rx_in_frame_r) begin
                        rx_frame_err <= rx_er_s;
                    end else if (rx_er_s) begin
                        rx_frame_err <= 1'b1;
                    end
                end else if (rx_in_frame_r) begin
                    rx_frame_end <= 1'b1;
                end
            end
        end
    end

    // Medium status.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            carrier_sense <= 1'b0;
            collision <= 1'b0;
        end else begin
            carrier_sense <= crs_s;
            collision <= col_s & ~full_duplex;
        end
    end

    // Management engine.
    mpmi_mg_state_t mg_state_r;
    logic [MDC_TW-1:0] mg_timer_r;
    logic [MGMT_CNT_W-1:0] mg_bit_r;
    logic [MGMT_FRAME_BITS-1:0] mg_shift_r;
    logic mg_write_r;
    logic mg_phase_end;

    localparam logic [MDC_TW-1:0] MG_TIMER_LAST =
        MDC_TW'(MDC_HALF_CYC - 1);
    localparam logic [MGMT_CNT_W-1:0] MG_BIT_LAST =
        MGMT_CNT_W'(MGMT_FRAME_BITS - 1);
    localparam logic [MGMT_CNT_W-1:0] MG_TA_POS = MGMT_CNT_W'(MGMT_TA_BIT);
    localparam logic [MGMT_CNT_W-1:0] MG_DATA_POS =
        MGMT_CNT_W'(MGMT_DATA_BIT);

    assign mg_phase_end = (mg_timer_r == MG_TIMER_LAST);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mg_state_r <= MPMI_MG_IDLE;
            mg_timer_r <= '0;
            mg_bit_r <= '0;
            mg_shift_r <= '0;
            mg_write_r <= 1'b0;
            phy_mdc <= 1'b0;
            phy_mdio_o <= 1'b0;
            phy_mdio_oe <= 1'b0;
            mgmt_busy <= 1'b0;
            mgmt_done <= 1'b0;
            mgmt_rdata <= RDATA_RST;
        end else begin
            mgmt_done <= 1'b0;
            unique case (mg_state_r)
                MPMI_MG_IDLE: begin
                    // The clock simply parks low between frames.
                    phy_mdc <= 1'b0;
                    if (mgmt_start) begin
                        mg_shift_r <= {MGMT_PREAMBLE, MGMT_START,
                            mgmt_write ? MGMT_OP_WRITE : MGMT_OP_READ,
                            mgmt_phy_addr, mgmt_reg_addr, MGMT_TA_WRITE,
                            mgmt_write ? mgmt_wdata : 16'h0000};
                        mg_write_r <= mgmt_write;
                        mg_bit_r <= '0;
                        mg_timer_r <= '0;
                        phy_mdio_o <= MGMT_PREAMBLE[31];
                        phy_mdio_oe <= 1'b1;
                        mgmt_busy <= 1'b1;
                        mg_state_r <= MPMI_MG_LOW;
                    end
                end
                MPMI_MG_LOW: begin
                    mg_timer_r <= mg_timer_r + 1'b1;
                    if (mg_phase_end) begin
                        mg_timer_r <= '0;
                        phy_mdc <= 1'b1;
                        if (!mg_write_r && mg_bit_r >= MG_DATA_POS) begin
                            mgmt_rdata <= {mgmt_rdata[14:0], mdio_s};
                        end
                        mg_state_r <= MPMI_MG_HIGH;
                    end
                end
                MPMI_MG_HIGH: begin
                    mg_timer_r <= mg_timer_r + 1'b1;
                    if (mg_phase_end) begin
                        mg_timer_r <= '0;
                        phy_mdc <= 1'b0;
                        if (mg_bit_r == MG_BIT_LAST) begin
                            phy_mdio_oe <= 1'b0;
                            phy_mdio_o <= 1'b0;
                            mgmt_busy <= 1'b0;
                            mgmt_done <= 1'b1;
                            mg_state_r <= MPMI_MG_IDLE;
                        end else begin
                            mg_bit_r <= mg_bit_r + 1'b1;
                            mg_shift_r <= {mg_shift_r[62:0], 1'b0};
                            phy_mdio_o <= mg_shift_r[62];
                            phy_mdio_oe <= mg_write_r ||
                                (mg_bit_r + 1'b1 < MG_TA_POS);
                            mg_state_r <= MPMI_MG_LOW;
                        end
                    end
                end
            endcase
        end
    end
endmodule : mpmi_top
`default_nettype wire

/* File: mpmi_pkg.sv */
`default_nettype none
package mpmi_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MDC_MIN_PHASE_NS = 160;
    localparam int MDC_MIN_PERIOD_NS = 400;
    localparam int MDC_HALF_NS = (MDC_MIN_PERIOD_NS / 2 > MDC_MIN_PHASE_NS) ?
        MDC_MIN_PERIOD_NS / 2 : MDC_MIN_PHASE_NS;
    localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam int MDC_TW = $clog2(MDC_HALF_CYC + 1);
    localparam int NIB_W = 4;
    localparam int MGMT_FRAME_BITS = 64;
    localparam int MGMT_TA_BIT = 46;
    localparam int MGMT_DATA_BIT = 48;
    localparam int MGMT_CNT_W = 6;
    localparam logic [31:0] MGMT_PREAMBLE = 32'hFFFFFFFF;
    localparam logic [1:0] MGMT_START = 2'h1;
    localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
    localparam logic [1:0] MGMT_OP_READ = 2'h2;
    localparam logic [1:0] MGMT_TA_WRITE = 2'h2;
    localparam logic [3:0] TXD_RST = 4'h0;
    localparam logic [15:0] RDATA_RST = 16'h0000;

    typedef enum logic [1:0] {
        MPMI_MG_IDLE,
        MPMI_MG_LOW,
        MPMI_MG_HIGH
    } mpmi_mg_state_t;

    // In the serial coder mode only lane 0 carries data.
    function automatic logic [3:0] mpmi_lane_sel(input logic serial,
                                                 input logic [3:0] nib);
        mpmi_lane_sel = serial ? {3'h0, nib[0]} : nib;
    endfunction : mpmi_lane_sel
endpackage : mpmi_pkg
`default_nettype wire

/* File: mpmi_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mpmi_chk (
    // Clock, reset and modes
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic serial_coder_10m_mode,
    input wire logic full_duplex,
    // Outputs watched
    input wire logic tx_taken,
    input wire logic phy_tx_en,
    input wire logic [3:0] phy_txd,
    input wire logic rx_nib_valid,
    input wire logic [3:0] rx_nib,
    input wire logic rx_frame_err,
    input wire logic collision,
    input wire logic mgmt_busy,
    input wire logic mgmt_done,
    input wire logic phy_mdc,
    input wire logic phy_mdio_o,
    input wire logic phy_mdio_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_txd_idle_zero: assert property (!phy_tx_en |-> phy_txd == 4'h0)
        else $error("txd not zero while idle");
    a_serial_tx_lane: assert property (serial_coder_10m_mode && phy_tx_en
        |-> phy_txd[3:1] == 3'h0) else $error("upper txd lanes used");
    a_tx_en_holds: assert property (tx_taken |-> phy_tx_en [*7])
        else $error("tx_en dropped inside a period");
    a_serial_rx_lane: assert property (rx_nib_valid
        && serial_coder_10m_mode |-> rx_nib[3:1] == 3'h0)
        else $error("upper rxd lanes taken");
    a_err_needs_nib: assert property ($rose(rx_frame_err)
        |-> rx_nib_valid) else $error("frame error set without valid data");
    a_done_ends_busy: assert property (mgmt_done |-> !mgmt_busy)
        else $error("busy still high at frame end");
    a_col_fdx_off: assert property (full_duplex && $past(full_duplex)
        |-> !collision) else $error("collision shown in full duplex");
    a_mdc_high_len: assert property ($rose(phy_mdc) |-> phy_mdc [*8])
        else $error("mdc high phase too short");
    a_mdc_low_len: assert property ($fell(phy_mdc) |-> !phy_mdc [*8])
        else $error("mdc low phase too short");
    a_mdio_steady: assert property (phy_mdio_oe && phy_mdc
        |-> $stable(phy_mdio_o)) else $error("mdio moved while mdc high");
    cover property (rx_nib_valid && rx_frame_err);
    cover property (tx_taken && serial_coder_10m_mode);
    cover property (mgmt_done);
    cover property (phy_mdc && !phy_mdio_oe);
endmodule : mpmi_chk
bind mpmi_top mpmi_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .serial_coder_10m_mode(serial_coder_10m_mode),
    .full_duplex(full_duplex), .tx_taken(tx_taken), .phy_tx_en(phy_tx_en),
    .phy_txd(phy_txd), .rx_nib_valid(rx_nib_valid), .rx_nib(rx_nib),
    .rx_frame_err(rx_frame_err), .collision(collision),
    .mgmt_busy(mgmt_busy), .mgmt_done(mgmt_done), .phy_mdc(phy_mdc),
    .phy_mdio_o(phy_mdio_o), .phy_mdio_oe(phy_mdio_oe));
`default_nettype wire

/* File: mpmi_phy.sv */
`timescale 1ns/1ps
`default_nettype none
module mpmi_phy (
    // Clocks and receive lines
    output var logic tx_clk,
    output var logic rx_clk,
    output var logic rx_dv,
    output var logic rx_er,
    output var logic [3:0] rxd,
    // Management lines
    input wire logic mdc,
    input wire logic mdo,
    input wire logic oe,
    output logic mdi
);
    logic [17:0] sh;
    logic drv;
    logic bit_r;
    initial begin
        {rx_dv, rx_er, rxd} = 6'h05;
        drv = 0;
        tx_clk = 0;
        rx_clk = 0;
        #37;
        forever begin
            #100 tx_clk = ~tx_clk;
            rx_clk = ~tx_clk;
        end
    end
    // Turnaround zero, data, then the pull-up level once released.
    always @(posedge mdc or posedge oe) begin
        if (oe) begin
            sh = {1'h0, 16'hA5C3, 1'h1};
            drv = 0;
        end else begin
            drv = 1;
            bit_r = sh[17];
            sh = sh << 1;
        end
    end
    assign mdi = oe ? mdo : (drv ? bit_r : 1'h1);
    task automatic rx_frame(input int n, input logic [3:0] b, input int e);
        @(posedge rx_clk);
        rx_er = (e == -2);
        for (int i = 0; i < n; i++) begin
            @(posedge rx_clk);
            rx_dv = 1;
            rx_er = (i == e);
            rxd = b + 4'(i);
        end
        @(posedge rx_clk);
        rx_dv = 0;
        rx_er = 0;
        rxd = ~rxd;
    endtask : rx_frame
endmodule : mpmi_phy
`default_nettype wire

/* File: mpmi_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module mpmi_top_bench;
    logic ref_clk = 0, rst_n = 0, serial_coder_10m_mode = 0, full_duplex = 0;
    logic tx_valid = 0, phy_crs = 0, phy_col = 0, mgmt_start = 0;
    logic mgmt_write = 0, tx_taken, rx_nib_valid, rx_frame_end, rx_frame_err;
    logic carrier_sense, collision, mgmt_busy, mgmt_done, phy_tx_clk;
    logic phy_tx_en, phy_rx_clk, phy_rx_dv, phy_rx_er, phy_mdc;
    logic phy_mdio_i, phy_mdio_o, phy_mdio_oe;
    logic [3:0] tx_nibble = 0, rx_nib, phy_txd, phy_rxd;
    logic [4:0] mgmt_phy_addr = 0, mgmt_reg_addr = 0;
    logic [15:0] mgmt_wdata = 0, mgmt_rdata;
    int fails = 0, checks = 0;
    mpmi_top uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .serial_coder_10m_mode(serial_coder_10m_mode),
        .full_duplex(full_duplex), .tx_valid(tx_valid),
        .tx_nibble(tx_nibble), .tx_taken(tx_taken),
        .rx_nib_valid(rx_nib_valid), .rx_nib(rx_nib),
        .rx_frame_end(rx_frame_end), .rx_frame_err(rx_frame_err),
        .carrier_sense(carrier_sense), .collision(collision),
        .mgmt_start(mgmt_start), .mgmt_write(mgmt_write),
        .mgmt_phy_addr(mgmt_phy_addr), .mgmt_reg_addr(mgmt_reg_addr),
        .mgmt_wdata(mgmt_wdata), .mgmt_busy(mgmt_busy),
        .mgmt_done(mgmt_done), .mgmt_rdata(mgmt_rdata),
        .phy_tx_clk(phy_tx_clk), .phy_tx_en(phy_tx_en), .phy_txd(phy_txd),
        .phy_rx_clk(phy_rx_clk), .phy_rx_dv(phy_rx_dv),
        .phy_rx_er(phy_rx_er), .phy_rxd(phy_rxd), .phy_crs(phy_crs),
        .phy_col(phy_col), .phy_mdc(phy_mdc), .phy_mdio_i(phy_mdio_i),
        .phy_mdio_o(phy_mdio_o), .phy_mdio_oe(phy_mdio_oe));
    mpmi_phy phy (.tx_clk(phy_tx_clk), .rx_clk(phy_rx_clk), .rx_dv(phy_rx_dv),
        .rx_er(phy_rx_er), .rxd(phy_rxd), .mdc(phy_mdc), .mdo(phy_mdio_o),
        .oe(phy_mdio_oe), .mdi(phy_mdio_i));
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic stop_test;
        $display("fails=%0d checks=%0d", fails, checks);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // Every wait is bounded so a stuck handshake ends the run.
    task automatic wt(ref logic s, input logic v, input int n);
        for (int k = 0; k < n && s !== v; k++)
            @(negedge ref_clk);
        if (s !== v) begin
            fails++;
            stop_test();
        end
    endtask : wt
    task automatic tx_test(input logic m);
        serial_coder_10m_mode = m;
        for (int i = 0; i < 3; i++) begin
            tx_valid = 1;
            tx_nibble = 4'h9 + 4'(i);
            @(negedge ref_clk);
            wt(tx_taken, 1, 200);
            chk(phy_txd, m ? {3'h0, tx_nibble[0]} : tx_nibble);
            chk(phy_tx_en, 1);
        end
        tx_valid = 0;
        @(negedge ref_clk);
        wt(phy_tx_en, 0, 200);
        chk(phy_txd, 0);
    endtask : tx_test
    task automatic rx_test(input logic m, input int e);
        serial_coder_10m_mode = m;
        fork
            phy.rx_frame(4, 4'hC, e);
        join_none
        for (int i = 0; i < 4; i++) begin
            wt(rx_nib_valid, 1, 400);
            chk(rx_nib, m ? {3'h0, i[0]} : 4'hC + 4'(i));
            @(negedge ref_clk);
        end
        wt(rx_frame_end, 1, 400);
        chk(rx_frame_err, e >= 0);
    endtask : rx_test
    task automatic med_test;
        {phy_crs, phy_col} = 2'h3;
        repeat (5) @(negedge ref_clk);
        chk({carrier_sense, collision}, 2'h3);
        full_duplex = 1;
        repeat (5) @(negedge ref_clk);
        chk(collision, 0);
        {phy_crs, phy_col, full_duplex} = 3'h0;
        repeat (5) @(negedge ref_clk);
        chk(carrier_sense, 0);
    endtask : med_test
    task automatic mg_test(input logic w, input logic [15:0] d);
        logic [63:0] fr;
        logic [63:0] oe;
        logic [63:0] ex;
        ex = {32'hFFFFFFFF, 2'h1, w ? 2'h1 : 2'h2, 5'h15, 5'h0A, 2'h2, d};
        {mgmt_write, mgmt_phy_addr, mgmt_reg_addr, mgmt_wdata} =
            {w, 5'h15, 5'h0A, d};
        mgmt_start = 1;
        fork
            repeat (64) @(posedge phy_mdc) begin
                fr = {fr[62:0], phy_mdio_o};
                oe = {oe[62:0], phy_mdio_oe};
            end
        join_none
        @(negedge ref_clk);
        mgmt_start = 0;
        chk(mgmt_busy, 1);
        wt(mgmt_done, 1, 1100);
        chk(mgmt_busy, 0);
        chk(fr[63:18], ex[63:18]);
        chk(oe, w ? 64'hFFFFFFFFFFFFFFFF : 64'hFFFFFFFFFFFC0000);
        chk(w ? fr[17:0] : mgmt_rdata, w ? ex[17:0] : 18'h0A5C3);
    endtask : mg_test
    initial begin
        repeat (4) @(negedge ref_clk);
        rst_n = 1;
        repeat (4) @(negedge ref_clk);
        tx_test(0);
        tx_test(1);
        rx_test(0, 2);
        rx_test(0, -2);
        rx_test(1, -1);
        med_test();
        mg_test(1, 16'hC3A5);
        mg_test(0, 16'h0000);
        stop_test();
    end
endmodule : mpmi_top_bench
`default_nettype wire
